// file: rtl/iorsd_top.sv
`timescale 1ns/1ps
`include "iorsd_cfg.svh"

module iorsd_top
    import iorsd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire iorsd_req_type CORE_REQ,
    output iorsd_rsp_type CORE_RSP,
    input wire iorsd_pins_type PIN_LEVELS,
    input wire iorsd_events_type FLAG_EVENTS,
    output logic [63:0][7:0] IO_REGS,
    output logic [1:0] TIMER_FORCE
);

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    function automatic iorsd_kind_type kind_of(input logic [5:0] a);
        case (a)
            `IORSD_PORT_B_INPUT_LEVELS,
            `IORSD_PORT_C_INPUT_LEVELS,
            `IORSD_PORT_D_INPUT_LEVELS: kind_of = KIND_PIN;
            `IORSD_TIMER_ZERO_FLAGS,
            `IORSD_TIMER_ONE_FLAGS,
            `IORSD_TIMER_TWO_FLAGS,
            `IORSD_PIN_CHANGE_FLAGS: kind_of = KIND_W1C;
            `IORSD_PORT_B_DIRECTION,
            `IORSD_PORT_B_OUTPUT_LATCH,
            `IORSD_PORT_C_DIRECTION,
            `IORSD_PORT_C_OUTPUT_LATCH,
            `IORSD_PORT_D_DIRECTION,
            `IORSD_PORT_D_OUTPUT_LATCH,
            `IORSD_EXTERNAL_IRQ_MASK,
            `IORSD_SCRATCH_BYTE_ZERO,
            `IORSD_EEPROM_CONTROL,
            `IORSD_EEPROM_DATA_BYTE,
            `IORSD_EEPROM_ADDRESS_LOW,
            `IORSD_EEPROM_ADDRESS_HIGH,
            `IORSD_TIMER_PRESCALER_CONTROL,
            `IORSD_TIMER_ZERO_CONTROL_A,
            `IORSD_TIMER_ZERO_CONTROL_B,
            `IORSD_TIMER_ZERO_COUNT,
            `IORSD_TIMER_ZERO_COMPARE_A,
            `IORSD_TIMER_ZERO_COMPARE_B,
            `IORSD_SCRATCH_BYTE_ONE,
            `IORSD_SCRATCH_BYTE_TWO: kind_of = KIND_RW;
            default: kind_of = KIND_NONE;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input logic [5:0] a);
        case (a)
            `IORSD_PORT_C_INPUT_LEVELS,
            `IORSD_PORT_C_DIRECTION,
            `IORSD_PORT_C_OUTPUT_LATCH: mask_of = `IORSD_MASK_PORT_C;
            `IORSD_TIMER_ZERO_FLAGS,
            `IORSD_TIMER_TWO_FLAGS: mask_of = `IORSD_MASK_TIMER_FLAGS;
            `IORSD_TIMER_ONE_FLAGS: mask_of = `IORSD_MASK_TIMER_ONE_FLAGS;
            `IORSD_PIN_CHANGE_FLAGS: mask_of = `IORSD_MASK_PIN_CHANGE;
            `IORSD_EXTERNAL_IRQ_MASK: mask_of = `IORSD_MASK_IRQ;
            `IORSD_EEPROM_CONTROL: mask_of = `IORSD_MASK_EEPROM_CONTROL;
            `IORSD_TIMER_PRESCALER_CONTROL: mask_of = `IORSD_MASK_PRESCALER;
            `IORSD_TIMER_ZERO_CONTROL_A: mask_of = `IORSD_MASK_CONTROL_A;
            `IORSD_TIMER_ZERO_CONTROL_B: mask_of = `IORSD_MASK_CONTROL_B;
            `IORSD_PORT_B_INPUT_LEVELS: mask_of = `IORSD_MASK_FULL;
            `IORSD_PORT_B_DIRECTION: mask_of = `IORSD_MASK_FULL;
            `IORSD_PORT_B_OUTPUT_LATCH: mask_of = `IORSD_MASK_FULL;
            `IORSD_PORT_D_INPUT_LEVELS: mask_of = `IORSD_MASK_FULL;
            `IORSD_PORT_D_DIRECTION: mask_of = `IORSD_MASK_FULL;
            `IORSD_PORT_D_OUTPUT_LATCH: mask_of = `IORSD_MASK_FULL;
            `IORSD_SCRATCH_BYTE_ZERO: mask_of = `IORSD_MASK_FULL;
            `IORSD_EEPROM_DATA_BYTE: mask_of = `IORSD_MASK_FULL;
            `IORSD_EEPROM_ADDRESS_LOW: mask_of = `IORSD_MASK_FULL;
            `IORSD_EEPROM_ADDRESS_HIGH: mask_of = `IORSD_MASK_FULL;
            `IORSD_TIMER_ZERO_COUNT: mask_of = `IORSD_MASK_FULL;
            `IORSD_TIMER_ZERO_COMPARE_A: mask_of = `IORSD_MASK_FULL;
            `IORSD_TIMER_ZERO_COMPARE_B: mask_of = `IORSD_MASK_FULL;
            `IORSD_SCRATCH_BYTE_ONE: mask_of = `IORSD_MASK_FULL;
            `IORSD_SCRATCH_BYTE_TWO: mask_of = `IORSD_MASK_FULL;
            default: mask_of = 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // register image
    // ----------------------------------------------------------------
    logic [63:0][7:0] regs_q;
    logic [63:0][7:0] regs_d;

    // ----------------------------------------------------------------
    // response and strobes
    // ----------------------------------------------------------------
    iorsd_pins_type pins_q;
    iorsd_rsp_type rsp_q;
    iorsd_rsp_type rsp_d;
    logic [1:0] force_q;
    logic [1:0] force_d;

    // ----------------------------------------------------------------
    // op class decode
    // ----------------------------------------------------------------
    wire logic is_data_op = (CORE_REQ.op == OP_DATA_LOAD) || (CORE_REQ.op == OP_DATA_STORE);
    wire logic is_bit_op = (CORE_REQ.op == OP_BIT_SET) || (CORE_REQ.op == OP_BIT_CLEAR)
                         || (CORE_REQ.op == OP_SKIP_HIGH) || (CORE_REQ.op == OP_SKIP_LOW);
    wire logic is_write_op = (CORE_REQ.op == OP_IO_OUT) || (CORE_REQ.op == OP_DATA_STORE)
                           || (CORE_REQ.op == OP_BIT_SET) || (CORE_REQ.op == OP_BIT_CLEAR);

    // ----------------------------------------------------------------
    // address views
    // ----------------------------------------------------------------
    wire logic [7:0] data_io_addr = CORE_REQ.addr - `IORSD_DATA_OFFSET;
    wire logic data_in_io = (CORE_REQ.addr >= `IORSD_DATA_OFFSET) && (CORE_REQ.addr < `IORSD_EXT_BASE);
    wire logic data_in_ext = CORE_REQ.addr >= `IORSD_EXT_BASE;
    wire logic direct_in_io = CORE_REQ.addr <= `IORSD_IO_TOP;
    wire logic [5:0] io_addr = is_data_op ? data_io_addr[5:0] : CORE_REQ.addr[5:0];
    wire logic bit_window = io_addr <= `IORSD_BIT_WIN_TOP;
    wire logic hits_io = is_data_op ? data_in_io : (direct_in_io && (!is_bit_op || bit_window));

    // ----------------------------------------------------------------
    // access outcome
    // ----------------------------------------------------------------
    wire iorsd_kind_type kind = kind_of(io_addr);
    wire logic [7:0] mask = mask_of(io_addr);
    wire logic reserved_write = is_write_op && (kind == KIND_NONE);
    wire logic ext_hit = is_data_op && data_in_ext;
    wire logic io_range_miss = !is_data_op && !direct_in_io;
    wire logic bit_range_miss = !is_data_op && is_bit_op && !bit_window;
    wire logic data_low_miss = is_data_op && !data_in_io && !data_in_ext;
    wire logic reject = CORE_REQ.valid
                      && (io_range_miss || bit_range_miss || data_low_miss || (reserved_write && !ext_hit));
    wire logic do_write = CORE_REQ.valid && is_write_op && hits_io && !reserved_write;
    wire logic [7:0] one_hot = 8'h01 << CORE_REQ.bit_sel;
    wire logic [5:0] latch_addr = 6'(io_addr + `IORSD_LATCH_STEP);

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] stored_value;

    // stored byte or registered pins per i/o address
    always_comb begin
        case (io_addr)
            // port registers
            `IORSD_PORT_B_INPUT_LEVELS: stored_value = pins_q.port_b;
            `IORSD_PORT_C_INPUT_LEVELS: stored_value = pins_q.port_c;
            `IORSD_PORT_D_INPUT_LEVELS: stored_value = pins_q.port_d;
            `IORSD_PORT_B_DIRECTION: stored_value = regs_q[`IORSD_PORT_B_DIRECTION];
            `IORSD_PORT_B_OUTPUT_LATCH: stored_value = regs_q[`IORSD_PORT_B_OUTPUT_LATCH];
            `IORSD_PORT_C_DIRECTION: stored_value = regs_q[`IORSD_PORT_C_DIRECTION];
            `IORSD_PORT_C_OUTPUT_LATCH: stored_value = regs_q[`IORSD_PORT_C_OUTPUT_LATCH];
            `IORSD_PORT_D_DIRECTION: stored_value = regs_q[`IORSD_PORT_D_DIRECTION];
            `IORSD_PORT_D_OUTPUT_LATCH: stored_value = regs_q[`IORSD_PORT_D_OUTPUT_LATCH];
            // flag registers
            `IORSD_TIMER_ZERO_FLAGS: stored_value = regs_q[`IORSD_TIMER_ZERO_FLAGS];
            `IORSD_TIMER_ONE_FLAGS: stored_value = regs_q[`IORSD_TIMER_ONE_FLAGS];
            `IORSD_TIMER_TWO_FLAGS: stored_value = regs_q[`IORSD_TIMER_TWO_FLAGS];
            `IORSD_PIN_CHANGE_FLAGS: stored_value = regs_q[`IORSD_PIN_CHANGE_FLAGS];
            // control, eeprom, timer and scratch registers
            `IORSD_EXTERNAL_IRQ_MASK: stored_value = regs_q[`IORSD_EXTERNAL_IRQ_MASK];
            `IORSD_SCRATCH_BYTE_ZERO: stored_value = regs_q[`IORSD_SCRATCH_BYTE_ZERO];
            `IORSD_EEPROM_CONTROL: stored_value = regs_q[`IORSD_EEPROM_CONTROL];
            `IORSD_EEPROM_DATA_BYTE: stored_value = regs_q[`IORSD_EEPROM_DATA_BYTE];
            `IORSD_EEPROM_ADDRESS_LOW: stored_value = regs_q[`IORSD_EEPROM_ADDRESS_LOW];
            `IORSD_EEPROM_ADDRESS_HIGH: stored_value = regs_q[`IORSD_EEPROM_ADDRESS_HIGH];
            `IORSD_TIMER_PRESCALER_CONTROL: stored_value = regs_q[`IORSD_TIMER_PRESCALER_CONTROL];
            `IORSD_TIMER_ZERO_CONTROL_A: stored_value = regs_q[`IORSD_TIMER_ZERO_CONTROL_A];
            `IORSD_TIMER_ZERO_CONTROL_B: stored_value = regs_q[`IORSD_TIMER_ZERO_CONTROL_B];
            `IORSD_TIMER_ZERO_COUNT: stored_value = regs_q[`IORSD_TIMER_ZERO_COUNT];
            `IORSD_TIMER_ZERO_COMPARE_A: stored_value = regs_q[`IORSD_TIMER_ZERO_COMPARE_A];
            `IORSD_TIMER_ZERO_COMPARE_B: stored_value = regs_q[`IORSD_TIMER_ZERO_COMPARE_B];
            `IORSD_SCRATCH_BYTE_ONE: stored_value = regs_q[`IORSD_SCRATCH_BYTE_ONE];
            `IORSD_SCRATCH_BYTE_TWO: stored_value = regs_q[`IORSD_SCRATCH_BYTE_TWO];
            default: stored_value = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // read result
    // ----------------------------------------------------------------
    wire logic [7:0] cur_value = stored_value & mask;
    wire logic [7:0] read_value = hits_io ? cur_value : 8'h00;
    wire logic tested_bit = read_value[CORE_REQ.bit_sel];

    // ----------------------------------------------------------------
    // write path: per-op bits written as one, set and kept
    // ----------------------------------------------------------------
    // byte writes drive all bits; bit ops drive only the selected one
    wire logic [7:0] ones_written = (CORE_REQ.op == OP_BIT_SET) ? one_hot :
                                    (CORE_REQ.op == OP_BIT_CLEAR) ? 8'h00 : CORE_REQ.wdata;
    wire logic [7:0] touched = is_bit_op ? one_hot : 8'hFF;
    wire logic [7:0] rw_value = (regs_q[io_addr] & ~(touched & mask)) | (ones_written & touched & mask);
    wire logic [7:0] w1c_value = regs_q[io_addr] & ~(ones_written & mask);

    // ----------------------------------------------------------------
    // latch toggle
    // ----------------------------------------------------------------
    // a one written to an input-level byte flips the matching latch bit
    wire logic [7:0] toggled_latch = regs_q[latch_addr] ^ (ones_written & mask);

    // ----------------------------------------------------------------
    // hardware flag sets
    // ----------------------------------------------------------------
    wire logic [7:0] timer_zero_sets = FLAG_EVENTS.timer_zero & `IORSD_MASK_TIMER_FLAGS;
    wire logic [7:0] timer_one_sets = FLAG_EVENTS.timer_one & `IORSD_MASK_TIMER_ONE_FLAGS;
    wire logic [7:0] timer_two_sets = FLAG_EVENTS.timer_two & `IORSD_MASK_TIMER_FLAGS;
    wire logic [7:0] pin_change_sets = FLAG_EVENTS.pin_change & `IORSD_MASK_PIN_CHANGE;

    // ----------------------------------------------------------------
    // next register image
    // ----------------------------------------------------------------
    always_comb begin
        regs_d = regs_q;
        if (do_write) begin
            case (io_addr)
                // input levels steer writes to their latch
                `IORSD_PORT_B_INPUT_LEVELS,
                `IORSD_PORT_C_INPUT_LEVELS,
                `IORSD_PORT_D_INPUT_LEVELS: regs_d[latch_addr] = toggled_latch;
                // flags clear on ones
                `IORSD_TIMER_ZERO_FLAGS,
                `IORSD_TIMER_ONE_FLAGS,
                `IORSD_TIMER_TWO_FLAGS,
                `IORSD_PIN_CHANGE_FLAGS: regs_d[io_addr] = w1c_value;
                // plain storage
                `IORSD_PORT_B_DIRECTION,
                `IORSD_PORT_B_OUTPUT_LATCH,
                `IORSD_PORT_C_DIRECTION,
                `IORSD_PORT_C_OUTPUT_LATCH,
                `IORSD_PORT_D_DIRECTION,
                `IORSD_PORT_D_OUTPUT_LATCH,
                `IORSD_EXTERNAL_IRQ_MASK,
                `IORSD_SCRATCH_BYTE_ZERO,
                `IORSD_EEPROM_CONTROL,
                `IORSD_EEPROM_DATA_BYTE,
                `IORSD_EEPROM_ADDRESS_LOW,
                `IORSD_EEPROM_ADDRESS_HIGH,
                `IORSD_TIMER_PRESCALER_CONTROL,
                `IORSD_TIMER_ZERO_CONTROL_A,
                `IORSD_TIMER_ZERO_CONTROL_B,
                `IORSD_TIMER_ZERO_COUNT,
                `IORSD_TIMER_ZERO_COMPARE_A,
                `IORSD_TIMER_ZERO_COMPARE_B,
                `IORSD_SCRATCH_BYTE_ONE,
                `IORSD_SCRATCH_BYTE_TWO: regs_d[io_addr] = rw_value;
                default: regs_d[io_addr] = regs_q[io_addr];
            endcase
        end
        // hardware set wins over a same-cycle software clear
        regs_d[`IORSD_TIMER_ZERO_FLAGS] = regs_d[`IORSD_TIMER_ZERO_FLAGS] | timer_zero_sets;
        regs_d[`IORSD_TIMER_ONE_FLAGS] = regs_d[`IORSD_TIMER_ONE_FLAGS] | timer_one_sets;
        regs_d[`IORSD_TIMER_TWO_FLAGS] = regs_d[`IORSD_TIMER_TWO_FLAGS] | timer_two_sets;
        regs_d[`IORSD_PIN_CHANGE_FLAGS] = regs_d[`IORSD_PIN_CHANGE_FLAGS] | pin_change_sets;
    end

    // ----------------------------------------------------------------
    // force strobes
    // ----------------------------------------------------------------
    wire logic [1:0] force_bits = (do_write && io_addr == `IORSD_TIMER_ZERO_CONTROL_B)
                                  ? ones_written[`IORSD_FORCE_LSB +: 2] : 2'b00;
    assign force_d = force_bits;

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    wire logic read_op = CORE_REQ.valid && !is_write_op;
    wire logic skip_high_hit = CORE_REQ.valid && hits_io && (CORE_REQ.op == OP_SKIP_HIGH);
    wire logic skip_low_hit = CORE_REQ.valid && hits_io && (CORE_REQ.op == OP_SKIP_LOW);

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = CORE_REQ.valid;
        rsp_d.reject = reject;
        rsp_d.ext = CORE_REQ.valid && ext_hit;
        if (read_op) begin
            rsp_d.rdata = read_value;
        end
        if (skip_high_hit) begin
            rsp_d.skip = tested_bit;
        end
        if (skip_low_hit) begin
            rsp_d.skip = !tested_bit;
        end
    end

    // ----------------------------------------------------------------
    // flops
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pins_q.port_b <= 8'h00;
            pins_q.port_c <= 8'h00;
            pins_q.port_d <= 8'h00;
        end else begin
            pins_q <= PIN_LEVELS;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rsp_q.valid <= 1'h0;
            rsp_q.rdata <= 8'h00;
            rsp_q.skip <= 1'h0;
            rsp_q.reject <= 1'h0;
            rsp_q.ext <= 1'h0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            force_q <= 2'b00;
        end else begin
            force_q <= force_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign CORE_RSP = rsp_q;
    assign IO_REGS = regs_q;
    assign TIMER_FORCE = force_q;

endmodule

// file: rtl/iorsd_cfg.svh
`ifndef IORSD_CFG_SVH
`define IORSD_CFG_SVH

// ----------------------------------------------------------------
// address views
// ----------------------------------------------------------------
`define IORSD_DATA_OFFSET 8'h20
`define IORSD_EXT_BASE 8'h60
`define IORSD_IO_TOP 8'h3F
`define IORSD_BIT_WIN_TOP 6'h1F
`define IORSD_LATCH_STEP 6'h02

// ----------------------------------------------------------------
// i/o addresses
// ----------------------------------------------------------------
`define IORSD_PORT_B_INPUT_LEVELS 6'h03
`define IORSD_PORT_B_DIRECTION 6'h04
`define IORSD_PORT_B_OUTPUT_LATCH 6'h05
`define IORSD_PORT_C_INPUT_LEVELS 6'h06
`define IORSD_PORT_C_DIRECTION 6'h07
`define IORSD_PORT_C_OUTPUT_LATCH 6'h08
`define IORSD_PORT_D_INPUT_LEVELS 6'h09
`define IORSD_PORT_D_DIRECTION 6'h0A
`define IORSD_PORT_D_OUTPUT_LATCH 6'h0B
`define IORSD_TIMER_ZERO_FLAGS 6'h15
`define IORSD_TIMER_ONE_FLAGS 6'h16
`define IORSD_TIMER_TWO_FLAGS 6'h17
`define IORSD_PIN_CHANGE_FLAGS 6'h1B
`define IORSD_EXTERNAL_IRQ_MASK 6'h1D
`define IORSD_SCRATCH_BYTE_ZERO 6'h1E
`define IORSD_EEPROM_CONTROL 6'h1F
`define IORSD_EEPROM_DATA_BYTE 6'h20
`define IORSD_EEPROM_ADDRESS_LOW 6'h21
`define IORSD_EEPROM_ADDRESS_HIGH 6'h22
`define IORSD_TIMER_PRESCALER_CONTROL 6'h23
`define IORSD_TIMER_ZERO_CONTROL_A 6'h24
`define IORSD_TIMER_ZERO_CONTROL_B 6'h25
`define IORSD_TIMER_ZERO_COUNT 6'h26
`define IORSD_TIMER_ZERO_COMPARE_A 6'h27
`define IORSD_TIMER_ZERO_COMPARE_B 6'h28
`define IORSD_SCRATCH_BYTE_ONE 6'h2A
`define IORSD_SCRATCH_BYTE_TWO 6'h2B

// ----------------------------------------------------------------
// implemented bit masks and reset value
// ----------------------------------------------------------------
`define IORSD_MASK_FULL 8'hFF
`define IORSD_MASK_PORT_C 8'h7F
`define IORSD_MASK_TIMER_FLAGS 8'h07
`define IORSD_MASK_TIMER_ONE_FLAGS 8'h27
`define IORSD_MASK_PIN_CHANGE 8'h07
`define IORSD_MASK_IRQ 8'h03
`define IORSD_MASK_EEPROM_CONTROL 8'h3F
`define IORSD_MASK_PRESCALER 8'h83
`define IORSD_MASK_CONTROL_A 8'hF3
`define IORSD_MASK_CONTROL_B 8'h0F
`define IORSD_FORCE_LSB 6
`define IORSD_RESET_VALUE 8'h00

`endif

// file: rtl/iorsd_pkg.sv
package iorsd_pkg;

    typedef enum logic [2:0] {
        OP_IO_IN,
        OP_IO_OUT,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_SKIP_HIGH,
        OP_SKIP_LOW,
        OP_DATA_LOAD,
        OP_DATA_STORE
    } iorsd_op_type;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_RW,
        KIND_W1C,
        KIND_PIN
    } iorsd_kind_type;

    typedef struct packed {
        logic valid;
        iorsd_op_type op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } iorsd_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic skip;
        logic reject;
        logic ext;
    } iorsd_rsp_type;

    typedef struct packed {
        logic [7:0] port_b;
        logic [7:0] port_c;
        logic [7:0] port_d;
    } iorsd_pins_type;

    typedef struct packed {
        logic [7:0] timer_zero;
        logic [7:0] timer_one;
        logic [7:0] timer_two;
        logic [7:0] pin_change;
    } iorsd_events_type;

endpackage

// file: verif/iorsd_assertions.sv
`timescale 1ns/1ps
module iorsd_assertions
    import iorsd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire iorsd_req_type CORE_REQ,
    input wire iorsd_rsp_type CORE_RSP,
    input wire iorsd_pins_type PIN_LEVELS,
    input wire iorsd_events_type FLAG_EVENTS,
    input wire logic [63:0][7:0] IO_REGS,
    input wire logic [1:0] TIMER_FORCE
);
    // ----------------------------------------------------------------
    // request decode and checks
    // ----------------------------------------------------------------
    wire logic rv = CORE_REQ.valid;
    wire logic qv = CORE_REQ.valid && (FLAG_EVENTS == '0);
    wire iorsd_op_type o = CORE_REQ.op;
    wire logic [7:0] a = CORE_REQ.addr;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    a_answer_next_cycle: assert property (rv |=> CORE_RSP.valid)
        else $error("no response one cycle after request");
    a_io_range_refused: assert property (qv && (o == OP_IO_IN || o == OP_IO_OUT) && a > 8'h3F
        |=> CORE_RSP.reject && $stable(IO_REGS)) else $error("i/o access above 0x3F not refused");
    a_bit_window_refused: assert property (qv && (o == OP_BIT_SET || o == OP_BIT_CLEAR) && a > 8'h1F
        |=> CORE_RSP.reject && $stable(IO_REGS)) else $error("bit op above 0x1F not refused");
    a_bit_set_single: assert property (rv && o == OP_BIT_SET && a == 8'h05
        |=> IO_REGS[5] == ($past(IO_REGS[5]) | (8'h01 << $past(CORE_REQ.bit_sel))))
        else $error("bit set changed wrong bits");
    a_bit_clear_single: assert property (rv && o == OP_BIT_CLEAR && a == 8'h05
        |=> IO_REGS[5] == ($past(IO_REGS[5]) & ~(8'h01 << $past(CORE_REQ.bit_sel))))
        else $error("bit clear changed wrong bits");
    a_skip_high_bit: assert property (rv && o == OP_SKIP_HIGH && a == 8'h05
        |=> CORE_RSP.skip == $past(IO_REGS[5][CORE_REQ.bit_sel])) else $error("skip high wrong");
    a_skip_low_bit: assert property (rv && o == OP_SKIP_LOW && a == 8'h05
        |=> CORE_RSP.skip != $past(IO_REGS[5][CORE_REQ.bit_sel])) else $error("skip low wrong");
    a_flags_clear_ones: assert property (qv && o == OP_IO_OUT && a == 8'h15
        |=> IO_REGS[21] == ($past(IO_REGS[21]) & ~$past(CORE_REQ.wdata))) else $error("flag clear wrong");
    a_data_view_offset: assert property (rv && o == OP_DATA_STORE && a == 8'h2A
        |=> IO_REGS[10] == $past(CORE_REQ.wdata)) else $error("data view store missed");
    a_ext_not_served: assert property (qv && (o == OP_DATA_LOAD || o == OP_DATA_STORE) && a >= 8'h60
        |=> CORE_RSP.ext && !CORE_RSP.reject && $stable(IO_REGS)) else $error("extended access mishandled");
    a_reserved_reads_zero: assert property (rv && o == OP_IO_IN && a == 8'h0C
        |=> CORE_RSP.rdata == 8'h00 && !CORE_RSP.reject) else $error("reserved read not zero");
endmodule
bind iorsd_top iorsd_assertions u_iorsd_assertions(.SYS_CLK(SYS_CLK), .SRST(SRST), .CORE_REQ(CORE_REQ),
    .CORE_RSP(CORE_RSP), .PIN_LEVELS(PIN_LEVELS), .FLAG_EVENTS(FLAG_EVENTS), .IO_REGS(IO_REGS),
    .TIMER_FORCE(TIMER_FORCE));

// file: verif/iorsd_core_model.sv
`timescale 1ns/1ps
module iorsd_core_model
    import iorsd_pkg::*;
(
    input wire logic SYS_CLK,
    output iorsd_req_type CORE_REQ,
    input wire iorsd_rsp_type CORE_RSP
);
    // ----------------------------------------------------------------
    // one access: held over the taking edge, answer read 1 unit after that same edge
    // ----------------------------------------------------------------
    initial CORE_REQ = '0;
    task automatic access(input iorsd_op_type op, input logic [7:0] addr, input logic [2:0] bsel,
        input logic [7:0] wd, output iorsd_rsp_type rsp);
        @(posedge SYS_CLK);
        #1;
        CORE_REQ = '{valid: 1'h1, op: op, addr: addr, bit_sel: bsel, wdata: wd};
        @(posedge SYS_CLK);
        #1;
        rsp = CORE_RSP;
        CORE_REQ = '{valid: 1'h0, op: op, addr: ~addr, bit_sel: ~bsel, wdata: ~wd};
    endtask
endmodule

// file: verif/iorsd_bench.sv
`timescale 1ns/1ps
module iorsd_bench
    import iorsd_pkg::*;
;
    logic sys_clk = 1'h0;
    logic srst = 1'h1;
    iorsd_req_type core_req;
    iorsd_rsp_type core_rsp;
    iorsd_pins_type pin_levels = '0;
    iorsd_events_type flag_events = '0;
    logic [63:0][7:0] io_regs;
    logic [1:0] timer_force;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    iorsd_rsp_type r;
    logic [7:0] wa [3] = '{8'h04, 8'h08, 8'h2B};
    logic [7:0] wd [3] = '{8'hA5, 8'hFF, 8'h3C};
    logic [7:0] we [3] = '{8'hA5, 8'h7F, 8'h3C};
    iorsd_op_type bo [4] = '{OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_HIGH, OP_SKIP_LOW};
    always #4 sys_clk = ~sys_clk;
    iorsd_top u_iorsd_top(.SYS_CLK(sys_clk), .SRST(srst), .CORE_REQ(core_req), .CORE_RSP(core_rsp),
        .PIN_LEVELS(pin_levels), .FLAG_EVENTS(flag_events), .IO_REGS(io_regs), .TIMER_FORCE(timer_force));
    iorsd_core_model u_iorsd_core_model(.SYS_CLK(sys_clk), .CORE_REQ(core_req), .CORE_RSP(core_rsp));
    // ----------------------------------------------------------------
    // helpers and sequence
    // ----------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic op(input iorsd_op_type o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
        u_iorsd_core_model.access(o, a, b, w, r);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        srst = 1'h0;
        pin_levels.port_c = 8'hFF;
        check(io_regs[5], 8'h00);
        for (int i = 0; i < 3; i++) begin
            op(OP_IO_OUT, wa[i], 3'h0, wd[i]);
            op(OP_IO_IN, wa[i], 3'h0, 8'h00);
            check(r.rdata, we[i]);
        end
        op(OP_IO_IN, 8'h06, 3'h0, 8'h00);
        check(r.rdata, 8'h7F);
        op(OP_DATA_STORE, 8'h2A, 3'h0, 8'h96);
        check(io_regs[10], 8'h96);
        op(OP_DATA_LOAD, 8'h24, 3'h0, 8'h00);
        check(r.rdata, 8'hA5);
        op(OP_DATA_LOAD, 8'h10, 3'h0, 8'h00);
        check(r.reject, 1'h1);
        op(OP_DATA_STORE, 8'h60, 3'h0, 8'h11);
        check({r.ext, r.reject}, 2'h2);
        op(OP_IO_OUT, 8'h40, 3'h0, 8'h11);
        check(r.reject, 1'h1);
        op(OP_IO_OUT, 8'h05, 3'h0, 8'h81);
        op(OP_BIT_SET, 8'h05, 3'h3, 8'h00);
        check(io_regs[5], 8'h89);
        op(OP_BIT_CLEAR, 8'h05, 3'h7, 8'h00);
        check(io_regs[5], 8'h09);
        op(OP_SKIP_HIGH, 8'h05, 3'h3, 8'h00);
        check(r.skip, 1'h1);
        op(OP_SKIP_LOW, 8'h05, 3'h2, 8'h00);
        check(r.skip, 1'h1);
        op(OP_IO_OUT, 8'h03, 3'h0, 8'h01);
        check(io_regs[5], 8'h08);
        for (int i = 0; i < 4; i++) begin
            op(bo[i], 8'h24, 3'h0, 8'h00);
            check({r.reject, io_regs[36]}, 9'h100);
        end
        @(posedge sys_clk);
        #1;
        flag_events.timer_zero = 8'h07;
        @(posedge sys_clk);
        #1;
        flag_events.timer_zero = 8'h00;
        op(OP_IO_OUT, 8'h15, 3'h0, 8'h00);
        check(io_regs[21], 8'h07);
        op(OP_IO_OUT, 8'h15, 3'h0, 8'h02);
        check(io_regs[21], 8'h05);
        op(OP_BIT_SET, 8'h15, 3'h2, 8'h00);
        check(io_regs[21], 8'h01);
        op(OP_IO_OUT, 8'h0C, 3'h0, 8'h55);
        check({r.reject, io_regs[12]}, 9'h100);
        op(OP_IO_IN, 8'h0C, 3'h0, 8'h00);
        check({r.reject, r.rdata}, 9'h000);
        op(OP_IO_OUT, 8'h25, 3'h0, 8'hC3);
        check(timer_force, 2'h3);
        op(OP_IO_IN, 8'h25, 3'h0, 8'h00);
        check(r.rdata, 8'h03);
        give_verdict();
    end
endmodule
